// ===== src/amd_pkg.sv
// Constants and types shared by the address map decoder
// Behaviour
// - 16-bit low-byte and word writes strobe low
// - 8-bit cycles strobe low on every write
// - Config bit two picks combined or low strobe
// - Listed external ranges go to the bus
// - FF2080 to FFDFFF is program memory
// - FF2000 to FF207F is special-purpose memory
// - FF0000 to FF00FF reserved for emulator
// - 0F0000 to FEFFFF is reserved overlay memory
// - 001F00 to 001FFF are peripheral registers
// - 000100 to 0003FF upper register RAM, no direct
// - 00001A to 0000FF lower register RAM
// - 000018 to 000019 hold the stack pointer
// - 000000 to 000017 are CPU registers
// - 002000 to 00DFFF external or remapped ROM
// - Program area internal if rom_bit_a and pin high
// - Clocks derive from the crystal input
// - High strobe for high-byte and word, all 8-bit
package amd_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int ADDR_W = 24; // Full CPU address
	localparam int REGION_W = 18; // One-hot region select width

	// ****************************************
	// Region boundaries, inclusive
	// ****************************************
	localparam logic [23:0] EXT_TOP_LO = 24'hffe000;
	localparam logic [23:0] EXT_TOP_HI = 24'hffffff;
	localparam logic [23:0] PROG_LO = 24'hff2080;
	localparam logic [23:0] PROG_HI = 24'hffdfff;
	localparam logic [23:0] SPM_LO = 24'hff2000;
	localparam logic [23:0] SPM_HI = 24'hff207f;
	localparam logic [23:0] EXT_FF_LO = 24'hff0100;
	localparam logic [23:0] EXT_FF_HI = 24'hff1fff;
	localparam logic [23:0] EMU_LO = 24'hff0000;
	localparam logic [23:0] EMU_HI = 24'hff00ff;
	localparam logic [23:0] OVL_LO = 24'h0f0000;
	localparam logic [23:0] OVL_HI = 24'hfeffff;
	localparam logic [23:0] EXT_HI_LO = 24'h010000;
	localparam logic [23:0] EXT_HI_HI = 24'h0effff;
	localparam logic [23:0] EXT_E_LO = 24'h00e000;
	localparam logic [23:0] EXT_E_HI = 24'h00ffff;
	localparam logic [23:0] RMP_LO = 24'h002000;
	localparam logic [23:0] RMP_HI = 24'h00dfff;
	localparam logic [23:0] PSFR_LO = 24'h001f00;
	localparam logic [23:0] PSFR_HI = 24'h001fff;
	localparam logic [23:0] EXT_LO_LO = 24'h000400;
	localparam logic [23:0] EXT_LO_HI = 24'h001eff;
	localparam logic [23:0] URF_LO = 24'h000100;
	localparam logic [23:0] URF_HI = 24'h0003ff;
	localparam logic [23:0] LRF_LO = 24'h00001a;
	localparam logic [23:0] LRF_HI = 24'h0000ff;
	localparam logic [23:0] SP_LO = 24'h000018;
	localparam logic [23:0] SP_HI = 24'h000019;
	localparam logic [23:0] CSFR_LO = 24'h000000;
	localparam logic [23:0] CSFR_HI = 24'h000017;

	// ****************************************
	// Configuration bit positions
	// ****************************************
	localparam int CFG0_WR_MODE_BIT = 2; // 1 combined strobe, 0 low
	localparam int CFG1_ROM_MAP_BIT = 2; // Internal ROM rom_bit_a

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] CFG0_RST = 8'h00;
	localparam logic [7:0] CFG1_RST = 8'h00;

	// Region index into the one-hot select vector
	typedef enum logic [4:0] {
		AMD_EXT_TOP, AMD_PROG, AMD_SPM, AMD_EXT_FF, AMD_EMU, AMD_OVL,
		AMD_EXT_HI, AMD_EXT_E, AMD_EXT_RMP, AMD_ROM_RMP, AMD_PSFR,
		AMD_EXT_LO, AMD_URF, AMD_LRF, AMD_SP, AMD_CSFR, AMD_ROM_PROG,
		AMD_ROM_SPM
	} amd_region_t;

	// Addressing mode bits: direct, indirect, indexed, extended, window
	typedef logic [4:0] amd_modes_t;
	localparam amd_modes_t MODE_NONE = 5'h00;
	localparam amd_modes_t MODE_IIE = 5'h0e; // Indirect indexed extended
	localparam amd_modes_t MODE_IIEW = 5'h1e; // Plus windowed direct
	localparam amd_modes_t MODE_IIW = 5'h16; // No direct, no extended
	localparam amd_modes_t MODE_DIIW = 5'h17; // Direct, ind, idx, window

endpackage

// ===== src/amd_range_cmp.sv
// Inclusive address range comparator
`timescale 1ns/1ps
`default_nettype none
module amd_range_cmp #(
	parameter logic [23:0] LO = 24'h000000,
	parameter logic [23:0] HI = 24'hffffff
) (
	// Address in
	input wire logic [23:0] addr_in,
	// Hit out
	output logic hit_out
);

	// Full-width compare so aliases never match
	assign hit_out = (addr_in >= LO) && (addr_in <= HI);

endmodule
`default_nettype wire

// ===== src/amd_decoder.sv
// Address map decoder with write strobe generation
`timescale 1ns/1ps
`default_nettype none
module amd_decoder #(
	parameter bit ROM_PRESENT = 1'b1 // Variant carries internal ROM
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// Crystal-derived clock enable, one pulse per internal state
	input wire logic crystal_input_in,
	// CPU address path
	input wire logic [23:0] addr_in,
	input wire logic addr_valid_in,
	input wire logic wr_in,
	input wire logic [1:0] byte_en_in,
	input wire logic bus16_in,
	// Configuration
	input wire logic [7:0] chip_config_reg_zero_in,
	input wire logic [7:0] chip_config_byte_one_in,
	input wire logic external_access_pin_in,
	// Region selects, one-hot
	output logic [17:0] region_sel_out,
	output logic external_out,
	output logic [4:0] modes_out,
	// Bus strobes, active low
	output logic low_byte_write_strobe_b_out,
	output logic high_byte_write_strobe_b_out,
	output logic byte_high_en_b_out,
	// Clock output pin
	output logic clock_output_pin_out
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [17:0] sel; // Registered region select
		logic ext; // Registered external flag
		logic [4:0] modes; // Permitted addressing modes
		logic lo_wr_b; // Low or combined write strobe
		logic hi_wr_b; // High strobe or byte-high enable
		logic bhe_b; // Byte-high enable copy
		logic clk_out; // Divided clock output
	} amd_state_t;

	amd_state_t st_q;
	amd_state_t st_d;

	// ****************************************
	// Range hits
	// ****************************************
	logic [14:0] hit; // One bit per address range
	logic rom_bit_a_rom; // Low program window uses ROM
	logic prog_rom; // High program window uses ROM

	// One comparator per range; the chain below settles priority
	// Top external block, up to the last address
	amd_range_cmp #(
		.LO(amd_pkg::EXT_TOP_LO),
		.HI(amd_pkg::EXT_TOP_HI)
	) u_top (
		.addr_in(addr_in),
		.hit_out(hit[0])
	);
	// Program memory
	amd_range_cmp #(
		.LO(amd_pkg::PROG_LO),
		.HI(amd_pkg::PROG_HI)
	) u_prog (
		.addr_in(addr_in),
		.hit_out(hit[1])
	);
	// Special-purpose memory just below it
	amd_range_cmp #(
		.LO(amd_pkg::SPM_LO),
		.HI(amd_pkg::SPM_HI)
	) u_spm (
		.addr_in(addr_in),
		.hit_out(hit[2])
	);
	// External block above the emulator space
	amd_range_cmp #(
		.LO(amd_pkg::EXT_FF_LO),
		.HI(amd_pkg::EXT_FF_HI)
	) u_eff (
		.addr_in(addr_in),
		.hit_out(hit[3])
	);
	// Emulator space, never reached by software
	amd_range_cmp #(
		.LO(amd_pkg::EMU_LO),
		.HI(amd_pkg::EMU_HI)
	) u_emu (
		.addr_in(addr_in),
		.hit_out(hit[4])
	);
	// Overlay space kept for later parts
	amd_range_cmp #(
		.LO(amd_pkg::OVL_LO),
		.HI(amd_pkg::OVL_HI)
	) u_ovl (
		.addr_in(addr_in),
		.hit_out(hit[5])
	);
	// Upper external block
	amd_range_cmp #(
		.LO(amd_pkg::EXT_HI_LO),
		.HI(amd_pkg::EXT_HI_HI)
	) u_ehi (
		.addr_in(addr_in),
		.hit_out(hit[6])
	);
	// External block above the low program window
	amd_range_cmp #(
		.LO(amd_pkg::EXT_E_LO),
		.HI(amd_pkg::EXT_E_HI)
	) u_ee (
		.addr_in(addr_in),
		.hit_out(hit[7])
	);
	// Low program window, ROM or bus
	amd_range_cmp #(
		.LO(amd_pkg::RMP_LO),
		.HI(amd_pkg::RMP_HI)
	) u_rmp (
		.addr_in(addr_in),
		.hit_out(hit[8])
	);
	// Peripheral registers
	amd_range_cmp #(
		.LO(amd_pkg::PSFR_LO),
		.HI(amd_pkg::PSFR_HI)
	) u_psfr (
		.addr_in(addr_in),
		.hit_out(hit[9])
	);
	// Lower external block
	amd_range_cmp #(
		.LO(amd_pkg::EXT_LO_LO),
		.HI(amd_pkg::EXT_LO_HI)
	) u_elo (
		.addr_in(addr_in),
		.hit_out(hit[10])
	);
	// Upper register RAM
	amd_range_cmp #(
		.LO(amd_pkg::URF_LO),
		.HI(amd_pkg::URF_HI)
	) u_urf (
		.addr_in(addr_in),
		.hit_out(hit[11])
	);
	// Lower register RAM
	amd_range_cmp #(
		.LO(amd_pkg::LRF_LO),
		.HI(amd_pkg::LRF_HI)
	) u_lrf (
		.addr_in(addr_in),
		.hit_out(hit[12])
	);
	// Stack pointer word
	amd_range_cmp #(
		.LO(amd_pkg::SP_LO),
		.HI(amd_pkg::SP_HI)
	) u_sp (
		.addr_in(addr_in),
		.hit_out(hit[13])
	);
	// CPU registers from address zero
	amd_range_cmp #(
		.LO(amd_pkg::CSFR_LO),
		.HI(amd_pkg::CSFR_HI)
	) u_csfr (
		.addr_in(addr_in),
		.hit_out(hit[14])
	);

	// ****************************************
	// ROM steering
	// ****************************************
	// Low window follows the access pin alone; program window also needs the rom_bit_a bit
	assign rom_bit_a_rom = ROM_PRESENT && external_access_pin_in;
	assign prog_rom = ROM_PRESENT && external_access_pin_in &&
		chip_config_byte_one_in[amd_pkg::CFG1_ROM_MAP_BIT];

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic [17:0] sel;
		logic wr_low;
		logic wr_high;
		logic combined;
		sel = 18'h00000;
		wr_low = 1'b0;
		wr_high = 1'b0;
		combined = 1'b0;
		st_d = st_q;
		st_d.modes = amd_pkg::MODE_NONE;
		// Ranges are disjoint, so this chain picks one only
		if (hit[0]) begin
			// Top external block
			sel[amd_pkg::AMD_EXT_TOP] = 1'b1;
			st_d.modes = amd_pkg::MODE_IIE;
		end else if (hit[1]) begin
			// Program area in ROM or out on the bus
			if (prog_rom) begin
				sel[amd_pkg::AMD_ROM_PROG] = 1'b1;
			end else begin
				sel[amd_pkg::AMD_PROG] = 1'b1;
			end
			st_d.modes = amd_pkg::MODE_IIE;
		end else if (hit[2]) begin
			// Special-purpose area follows the program area
			if (prog_rom) begin
				sel[amd_pkg::AMD_ROM_SPM] = 1'b1;
			end else begin
				sel[amd_pkg::AMD_SPM] = 1'b1;
			end
			st_d.modes = amd_pkg::MODE_IIE;
		end else if (hit[3]) begin
			// External block above the emulator space
			sel[amd_pkg::AMD_EXT_FF] = 1'b1;
			st_d.modes = amd_pkg::MODE_IIE;
		end else if (hit[4]) begin
			// Emulator space, no mode reaches it
			sel[amd_pkg::AMD_EMU] = 1'b1;
			st_d.modes = amd_pkg::MODE_NONE;
		end else if (hit[5]) begin
			// Overlay space, internal
			sel[amd_pkg::AMD_OVL] = 1'b1;
			st_d.modes = amd_pkg::MODE_IIE;
		end else if (hit[6]) begin
			// Upper external block
			sel[amd_pkg::AMD_EXT_HI] = 1'b1;
			st_d.modes = amd_pkg::MODE_IIE;
		end else if (hit[7]) begin
			// External block above the low window
			sel[amd_pkg::AMD_EXT_E] = 1'b1;
			st_d.modes = amd_pkg::MODE_IIE;
		end else if (hit[8]) begin
			// Low program window: pin chooses ROM or bus
			if (rom_bit_a_rom) begin
				sel[amd_pkg::AMD_ROM_RMP] = 1'b1;
			end else begin
				sel[amd_pkg::AMD_EXT_RMP] = 1'b1;
			end
			st_d.modes = amd_pkg::MODE_IIE;
		end else if (hit[9]) begin
			// Peripheral registers also reachable through the window
			sel[amd_pkg::AMD_PSFR] = 1'b1;
			st_d.modes = amd_pkg::MODE_IIEW;
		end else if (hit[10]) begin
			// Lower external block
			sel[amd_pkg::AMD_EXT_LO] = 1'b1;
			st_d.modes = amd_pkg::MODE_IIE;
		end else if (hit[11]) begin
			// Upper register RAM, no plain direct mode
			sel[amd_pkg::AMD_URF] = 1'b1;
			st_d.modes = amd_pkg::MODE_IIW;
		end else if (hit[12]) begin
			// Lower register RAM
			sel[amd_pkg::AMD_LRF] = 1'b1;
			st_d.modes = amd_pkg::MODE_DIIW;
		end else if (hit[13]) begin
			// Stack pointer word
			sel[amd_pkg::AMD_SP] = 1'b1;
			st_d.modes = amd_pkg::MODE_DIIW;
		end else begin
			// Only 000000..000017 is left
			sel[amd_pkg::AMD_CSFR] = 1'b1;
			st_d.modes = amd_pkg::MODE_DIIW;
		end
		st_d.sel = sel;
		// External flag: every region that goes out on the bus
		st_d.ext = sel[amd_pkg::AMD_EXT_TOP] |
			sel[amd_pkg::AMD_PROG] |
			sel[amd_pkg::AMD_SPM] |
			sel[amd_pkg::AMD_EXT_FF] |
			sel[amd_pkg::AMD_EXT_HI] |
			sel[amd_pkg::AMD_EXT_E] |
			sel[amd_pkg::AMD_EXT_RMP] |
			sel[amd_pkg::AMD_EXT_LO];
		// Lane strobes only on external writes; in combined mode the high pin also goes low on external reads
		combined = chip_config_reg_zero_in[amd_pkg::CFG0_WR_MODE_BIT];
		if (addr_valid_in && wr_in && st_d.ext) begin
			if (!bus16_in) begin
				// Narrow bus: both strobes on every write
				wr_low = 1'b1;
				wr_high = 1'b1;
			end else begin
				// Wide bus: each lane strobes on its own enable
				wr_low = byte_en_in[0];
				wr_high = byte_en_in[1];
			end
		end
		if (combined) begin
			// Combined mode: pin is a plain write, partner is BHE
			st_d.lo_wr_b = !(addr_valid_in && wr_in && st_d.ext);
			st_d.hi_wr_b = !(addr_valid_in && st_d.ext && byte_en_in[1]);
		end else begin
			// Split mode: one strobe per byte lane
			st_d.lo_wr_b = !wr_low;
			st_d.hi_wr_b = !wr_high;
		end
		// Byte-high enable shows on reads too, so no write gating
		st_d.bhe_b = !(addr_valid_in && st_d.ext && byte_en_in[1]);
		// Clock out toggles on each crystal-derived tick
		st_d.clk_out = st_q.clk_out ^ crystal_input_in;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			// Strobes park high so the bus never sees a false write
			st_q.sel <= 18'h00000;
			st_q.ext <= 1'b0;
			st_q.modes <= amd_pkg::MODE_NONE;
			st_q.lo_wr_b <= 1'b1;
			st_q.hi_wr_b <= 1'b1;
			st_q.bhe_b <= 1'b1;
			st_q.clk_out <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign region_sel_out = st_q.sel;
	assign external_out = st_q.ext;
	assign modes_out = st_q.modes;
	assign low_byte_write_strobe_b_out = st_q.lo_wr_b;
	assign high_byte_write_strobe_b_out = st_q.hi_wr_b;
	assign byte_high_en_b_out = st_q.bhe_b;
	assign clock_output_pin_out = st_q.clk_out;

endmodule
`default_nettype wire

// ===== testbench/amd_decoder_asserts.sv
// Port-level property checker for the address map decoder
`timescale 1ns/1ps
`default_nettype none
module amd_decoder_asserts (
	// Clock, reset and inputs
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic crystal_input_in,
	input wire logic [23:0] addr_in,
	input wire logic addr_valid_in,
	input wire logic wr_in,
	input wire logic [1:0] byte_en_in,
	input wire logic bus16_in,
	input wire logic [7:0] chip_config_reg_zero_in,
	input wire logic [7:0] chip_config_byte_one_in,
	input wire logic external_access_pin_in,
	// Observed outputs
	input wire logic [17:0] region_sel_out,
	input wire logic external_out,
	input wire logic [4:0] modes_out,
	input wire logic low_byte_write_strobe_b_out,
	input wire logic high_byte_write_strobe_b_out,
	input wire logic clock_output_pin_out
);
	// One clock domain, so one default for all
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Shorthands: combined strobe mode, valid write, program ROM on
	wire logic comb = chip_config_reg_zero_in[2];
	wire logic vwr = addr_valid_in && wr_in;
	wire logic rom_on = chip_config_byte_one_in[2] && external_access_pin_in;

	a_one_region: assert property (
		addr_valid_in |=> $onehot(region_sel_out))
		else $error("region select not one-hot");
	a_top_external: assert property (
		addr_valid_in && addr_in >= 24'hffe000 |=> region_sel_out[0] && external_out)
		else $error("top block not external");
	a_emul_nomode: assert property (
		addr_valid_in && addr_in[23:8] == 16'hff00
		|=> region_sel_out[4] && modes_out == 5'h00)
		else $error("emulator area decoded wrongly");
	a_psfr_window: assert property (
		addr_valid_in && addr_in[23:8] == 16'h001f
		|=> region_sel_out[10] && modes_out == 5'h1e)
		else $error("peripheral registers decoded wrongly");
	a_low_word16: assert property (
		vwr && bus16_in && byte_en_in[0] && !comb
		|=> low_byte_write_strobe_b_out == !external_out)
		else $error("low strobe wrong on wide bus");
	a_low_all8: assert property (
		vwr && !bus16_in |=> low_byte_write_strobe_b_out == !external_out)
		else $error("low strobe wrong on narrow bus");
	a_combined_low: assert property (
		vwr && comb |=> low_byte_write_strobe_b_out == !external_out)
		else $error("combined strobe wrong");
	a_high_write: assert property (
		vwr && !comb && (!bus16_in || byte_en_in[1])
		|=> high_byte_write_strobe_b_out == !external_out)
		else $error("high strobe wrong");
	a_read_quiet: assert property (
		!vwr && !comb
		|=> low_byte_write_strobe_b_out && high_byte_write_strobe_b_out)
		else $error("strobe without a write");
	a_rom_rom_bit_a: assert property (
		addr_valid_in && addr_in >= 24'h002000 && addr_in <= 24'h00dfff
		|=> region_sel_out[9] == $past(external_access_pin_in))
		else $error("remapped ROM select wrong");
	a_prog_rom: assert property (
		addr_valid_in && addr_in >= 24'hff2080 && addr_in <= 24'hffdfff
		|=> region_sel_out[16] == $past(rom_on))
		else $error("program ROM select wrong");
	a_clock_toggle: assert property (
		1'b1 |=> (clock_output_pin_out ^ $past(clock_output_pin_out))
		== $past(crystal_input_in))
		else $error("clock output does not follow tick");
endmodule
`default_nettype wire

// ===== testbench/amd_ext_dev.sv
// External bus device model that counts the writes it receives
`timescale 1ns/1ps
`default_nettype none
module amd_ext_dev (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Low write strobe from the decoder, active low
	input wire logic low_strobe_b_in,
	// Writes seen
	output logic [15:0] low_cnt_out
);
	// One write latched per strobe cycle, as a plain memory would
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			low_cnt_out <= 16'h0000;
		end else begin
			low_cnt_out <= low_cnt_out + 16'(!low_strobe_b_in);
		end
	end
endmodule
`default_nettype wire

// ===== testbench/amd_decoder_tb.sv
// Self-checking bench for the address map decoder
`timescale 1ns/1ps
`default_nettype none
module amd_decoder_tb;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic tick = 1'b0;
	logic [23:0] addr = 24'h000000;
	logic valid = 1'b0, wr = 1'b0, bus16 = 1'b0, pin = 1'b0;
	logic [1:0] be = 2'h0;
	logic [7:0] cfg0 = 8'h00, cfg1 = 8'h00;
	logic [17:0] sel;
	logic [4:0] modes;
	logic ext, low_b, high_b, hbe_b, clk_out;
	logic [15:0] low_cnt;
	int miscompares = 0;
	int comparisons = 0;
	int exp_low = 0;
	// Region low bounds plus 000001 and FFFFFF; each is probed at and just below it
	logic [23:0] lows [16] = '{24'hffe000, 24'hff2080, 24'hff2000,
		24'hff0100, 24'hff0000, 24'h0f0000, 24'h010000, 24'h00e000,
		24'h002000, 24'h001f00, 24'h000400, 24'h000100, 24'h00001a,
		24'h000018, 24'h000001, 24'hffffff};

	always #2 ref_clk_in = ~ref_clk_in;
	// Clock-enable tick every other cycle, launched just after the edge
	always @(posedge ref_clk_in) tick <= #1 ~tick;

	amd_decoder amd_decoder_i (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.crystal_input_in(tick), .addr_in(addr), .addr_valid_in(valid),
		.wr_in(wr), .byte_en_in(be), .bus16_in(bus16),
		.chip_config_reg_zero_in(cfg0), .chip_config_byte_one_in(cfg1),
		.external_access_pin_in(pin), .region_sel_out(sel),
		.external_out(ext), .modes_out(modes),
		.low_byte_write_strobe_b_out(low_b),
		.high_byte_write_strobe_b_out(high_b),
		.byte_high_en_b_out(hbe_b), .clock_output_pin_out(clk_out));
	amd_ext_dev amd_ext_dev_i (.clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.low_strobe_b_in(low_b), .low_cnt_out(low_cnt));

	// Expected region index; earlier tests win, like a priority chain
	function automatic int exp_region(logic [23:0] a, logic p, logic r);
		if (a >= 24'hffe000) return 0;
		if (a >= 24'hff2080) return (p && r) ? 16 : 1;
		if (a >= 24'hff2000) return (p && r) ? 17 : 2;
		if (a >= 24'hff0100) return 3;
		if (a >= 24'hff0000) return 4;
		if (a >= 24'h0f0000) return 5;
		if (a >= 24'h010000) return 6;
		if (a >= 24'h00e000) return 7;
		if (a >= 24'h002000) return p ? 9 : 8;
		if (a >= 24'h001f00) return 10;
		if (a >= 24'h000400) return 11;
		if (a >= 24'h000100) return 12;
		if (a >= 24'h00001a) return 13;
		if (a >= 24'h000018) return 14;
		return 15;
	endfunction

	// Compare tasks: vectors and single pins
	task automatic chk_vec(logic [17:0] got, logic [17:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(logic got, logic exp);
		chk_vec({17'h0, got}, {17'h0, exp});
	endtask

	// One access: present it, let the sampling edge pass, settle
	task automatic access(logic [23:0] a, logic w, logic [1:0] b);
		addr = a;
		wr = w;
		be = b;
		valid = 1'b1;
		@(posedge ref_clk_in);
		#1;
	endtask

	// Read one address and judge select, modes and bus routing
	task automatic check_region(logic [23:0] a);
		int r;
		logic [4:0] m;
		r = exp_region(a, pin, cfg1[2]);
		m = (r == 4) ? 5'h00 : (r == 10) ? 5'h1e : (r == 12) ? 5'h16 :
			(r >= 13 && r <= 15) ? 5'h17 : 5'h0e;
		access(a, 1'b0, 2'h3);
		chk_vec(sel, 18'h1 << r);
		chk_vec({13'h0, modes}, {13'h0, m});
		chk_pin(ext, r inside {0, 1, 2, 3, 6, 7, 8, 11});
		chk_pin(low_b, 1'b1);
	endtask

	// Every boundary under all four pin and rom_bit_a settings
	task automatic t_region_walk();
		for (int c = 0; c < 4; c++) begin
			pin = c[0];
			cfg1 = {5'h00, c[1], 2'h0};
			for (int i = 0; i < 16; i++) begin
				check_region(lows[i]);
				check_region(lows[i] - 24'h1);
			end
		end
	endtask

	// Back-to-back writes over modes, widths, byte lanes, in and out
	task automatic t_strobes();
		logic lx, hx;
		logic [1:0] b;
		for (int m = 0; m < 24; m++) begin
			b = 2'(m / 8 + 1);
			bus16 = m[1];
			cfg0 = {5'h00, m[2], 2'h0};
			access(m[0] ? 24'h00e000 : 24'h000100, 1'b1, b);
			lx = !(m[0] && (m[2] || !m[1] || b[0]));
			hx = !(m[0] && (!m[1] || b[1]));
			exp_low += int'(!lx);
			chk_pin(low_b, lx);
			if (!m[2]) chk_pin(high_b, hx);
			else chk_pin(high_b, !(m[0] && b[1]));
			chk_pin(hbe_b, !(m[0] && b[1]));
		end
		// Reserved emulator bytes take a write but never reach the bus
		access(24'hff0000, 1'b1, 2'h3);
		chk_pin(low_b, 1'b1);
		// A write with no valid access must not strobe
		valid = 1'b0;
		@(posedge ref_clk_in);
		#1;
		chk_pin(low_b, 1'b1);
		chk_vec(18'(low_cnt), 18'(exp_low));
	endtask

	// Reset in mid-run clears outputs; first access after it decodes
	task automatic t_midreset();
		logic c0;
		access(24'h00e000, 1'b1, 2'h3);
		rst_b_in = 1'b0;
		#1;
		chk_vec(sel, 18'h0);
		chk_pin(low_b, 1'b1);
		chk_pin(clk_out, 1'b0);
		@(posedge ref_clk_in);
		#1;
		rst_b_in = 1'b1;
		access(24'h000018, 1'b0, 2'h3);
		chk_vec(sel, 18'h1 << 14);
		// Two edges hold exactly one tick, so the clock pin flips once
		c0 = clk_out;
		access(24'h000000, 1'b0, 2'h3);
		chk_vec(sel, 18'h1 << 15);
		access(24'h000019, 1'b0, 2'h3);
		chk_vec(sel, 18'h1 << 14);
		chk_pin(clk_out, !c0);
	endtask

	task automatic tally_and_finish();
		if (miscompares == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence after five cycles of reset
	initial begin
		repeat (5) @(posedge ref_clk_in);
		#1;
		rst_b_in = 1'b1;
		t_strobes();
		t_region_walk();
		t_midreset();
		tally_and_finish();
	end
	// Watchdog, far beyond the under two hundred cycles the tests need
	initial begin
		#20000;
		miscompares++;
		tally_and_finish();
	end
endmodule

bind amd_decoder amd_decoder_asserts amd_decoder_asserts_i (
	.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
	.crystal_input_in(crystal_input_in), .addr_in(addr_in),
	.addr_valid_in(addr_valid_in), .wr_in(wr_in), .byte_en_in(byte_en_in),
	.bus16_in(bus16_in), .chip_config_reg_zero_in(chip_config_reg_zero_in),
	.chip_config_byte_one_in(chip_config_byte_one_in),
	.external_access_pin_in(external_access_pin_in),
	.region_sel_out(region_sel_out), .external_out(external_out),
	.modes_out(modes_out),
	.low_byte_write_strobe_b_out(low_byte_write_strobe_b_out),
	.high_byte_write_strobe_b_out(high_byte_write_strobe_b_out),
	.clock_output_pin_out(clock_output_pin_out));
`default_nettype wire
